/* pkg/timeout_monitor_consts.vh */
// Function
// - Watch accesses for a response only while the detect enable bit is set.
// - With no response within the selected cycle count, drive an error response.
// - On a timeout, store the stalled address in the 64-bit capture register.
// - A timed-out core write sets the write bus error flag.
// - The write bus error flag drives interrupt source number 1.
// - A timed-out core read raises a bus error exception, no flag.
// - Other masters get the error response and set their own error bit.
// - While the debug port reset pin is deasserted, detection stays disabled.
// - Cycle select 11/10/01/00 gives 4096/2048/1024/512 cycles, reset to 11.
`ifndef TIMEOUT_MONITOR_CONSTS_VH
`define TIMEOUT_MONITOR_CONSTS_VH

// Register byte offsets, low and high word of each 64-bit register
`define OFS_SETUP_LO      16'hE000
`define OFS_SETUP_HI      16'hE004
`define OFS_CAPTURE_LO    16'hE018
`define OFS_CAPTURE_HI    16'hE01C
`define OFS_INT_STATUS    16'hE100
`define OFS_INT_MASK      16'hE104
`define OFS_WIDTH         16

// Chip setup register fields, low word
`define SETUP_ENABLE_BIT  14
`define SETUP_WERR_BIT    15
`define SETUP_SEL_LSB     25
`define SETUP_SEL_MSB     26
`define SETUP_SEL_RESET   2'h3
`define SETUP_ENABLE_RST  1'h0

// Interrupt status bits
`define INT_TIMEOUT_BIT   0
`define INT_WERR_BIT      1
`define INT_WIDTH         2

// Timeout length for select code 00
`define TIMEOUT_BASE      13'h0200
`define COUNT_WIDTH       13

// Bus master codes
`define MASTER_CORE       2'h0
`define MASTER_PCI        2'h1
`define MASTER_DMA        2'h2

// AHB encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY        1'h0
`define WORD_ZERO         32'h00000000
`define HALF_WIDTH        32

`endif

/* rtl/ahb_reg_port.v */
`timescale 1ns/1ps
`include "timeout_monitor_consts.vh"

module ahb_reg_port #(
    parameter AW = `OFS_WIDTH
) (
    input  wire          clk,
    input  wire          reset,
    input  wire          hsel,
    input  wire [AW-1:0] haddr,
    input  wire [1:0]    htrans,
    input  wire          hwrite,
    input  wire          hready,
    input  wire [31:0]   hwdata,
    output wire          rd_stb,
    output wire [AW-1:0] rd_addr,
    output wire          wr_stb,
    output wire [AW-1:0] wr_addr,
    output wire [31:0]   wr_data
);

    reg          wpend_ff;
    reg [AW-1:0] waddr_ff;
    wire         take;

    assign take    = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
    assign rd_stb  = take & ~hwrite;
    assign rd_addr = haddr;
    assign wr_stb  = wpend_ff & hready;
    assign wr_addr = waddr_ff;
    assign wr_data = hwdata;

    // Write address held over into the data phase
    always @(posedge clk) begin
        if (reset) begin
            wpend_ff <= 1'b0;
            waddr_ff <= {AW{1'b0}};
        end else if (hready) begin
            wpend_ff <= take & hwrite;
            waddr_ff <= haddr;
        end
    end

endmodule

/* rtl/bus_timeout_monitor.v */
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "timeout_monitor_consts.vh"

module bus_timeout_monitor #(
    parameter ADDR_W = 32,
    parameter CW     = `COUNT_WIDTH
) (
    input  wire              clk,
    input  wire              reset,
    // AHB-Lite register port
    input  wire              hsel,
    input  wire [31:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output wire              hreadyout,
    output wire              hresp,
    output wire [31:0]       hrdata,
    // Debug test port reset pin, active low
    input  wire              debug_reset_n,
    // Monitored internal bus
    input  wire              acc_start,
    input  wire [ADDR_W-1:0] acc_addr,
    input  wire              acc_write,
    input  wire [1:0]        acc_master,
    input  wire              acc_done,
    // Error delivery
    output wire              err_resp,
    output wire              core_bus_error,
    output wire              pci_error,
    output wire              dma_error,
    output wire              irq_source1,
    output wire              irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    reg                  dbg_meta_ff;
    reg                  dbg_sync_ff;

    reg                  enable_ff;
    reg [1:0]            sel_ff;
    reg                  werr_flag_ff;
    reg [63:0]           capture_ff;
    reg [`INT_WIDTH-1:0] status_ff;
    reg [`INT_WIDTH-1:0] mask_ff;

    reg                  busy_ff;
    reg [ADDR_W-1:0]     cur_addr_ff;
    reg                  cur_write_ff;
    reg [1:0]            cur_master_ff;
    reg [CW-1:0]         limit_ff;

    reg                  err_resp_ff;
    reg                  core_bus_error_ff;
    reg                  pci_error_ff;
    reg                  dma_error_ff;
    reg                  irq_ff;

    reg                  hreadyout_ff;
    reg                  hresp_ff;
    reg [31:0]           hrdata_ff;
    reg [31:0]           nxt_hrdata;

    reg                  nxt_werr_flag;
    reg [`INT_WIDTH-1:0] nxt_status;

    wire                 rd_stb;
    wire [15:0]          rd_addr;
    wire                 wr_stb;
    wire [15:0]          wr_addr;
    wire [31:0]          wr_data;

    wire                 detect_on;
    wire [CW-1:0]        limit;
    wire                 expired;
    wire                 timeout_evt;
    wire                 werr_evt;
    wire                 werr_clear;
    wire                 status_read;
    wire [31:0]          setup_lo_word;
    wire [63:0]          addr_ext;

    wire                 is_core;
    wire                 core_read_evt;
    wire                 pci_evt;
    wire                 dma_evt;

    ////////////////////////////////////////////////////////////////////////////////
    // Output drive

    assign hreadyout      = hreadyout_ff;
    assign hresp          = hresp_ff;
    assign hrdata         = hrdata_ff;
    assign err_resp       = err_resp_ff;
    assign core_bus_error = core_bus_error_ff;
    assign pci_error      = pci_error_ff;
    assign dma_error      = dma_error_ff;
    assign irq_source1    = werr_flag_ff;
    assign irq            = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port

    ahb_reg_port #(
        .AW      (`OFS_WIDTH)
    ) u_port (
        .clk     (clk),
        .reset   (reset),
        .hsel    (hsel),
        .haddr   (haddr[15:0]),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hready  (hready),
        .hwdata  (hwdata),
        .rd_stb  (rd_stb),
        .rd_addr (rd_addr),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data)
    );

    // Slave never stalls and never errors; size is always a word
    always @(posedge clk) begin
        if (reset) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= `HRESP_OKAY;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= `HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Debug pin synchroniser

    always @(posedge clk) begin
        if (reset) begin
            dbg_meta_ff <= 1'b0;
            dbg_sync_ff <= 1'b0;
        end else begin
            dbg_meta_ff <= debug_reset_n;
            dbg_sync_ff <= dbg_meta_ff;
        end
    end

    // Probe attached while the pin reads high
    assign detect_on = enable_ff & ~dbg_sync_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Timeout length decode

    assign limit = `TIMEOUT_BASE << sel_ff;

    // Length held per access, so a select write cannot skip the match
    always @(posedge clk) begin
        if (reset) begin
            limit_ff <= `TIMEOUT_BASE << `SETUP_SEL_RESET;
        end else if (acc_start) begin
            limit_ff <= limit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Access tracking

    always @(posedge clk) begin
        if (reset) begin
            busy_ff       <= 1'b0;
            cur_addr_ff   <= {ADDR_W{1'b0}};
            cur_write_ff  <= 1'b0;
            cur_master_ff <= `MASTER_CORE;
        end else if (acc_start) begin
            busy_ff       <= 1'b1;
            cur_addr_ff   <= acc_addr;
            cur_write_ff  <= acc_write;
            cur_master_ff <= acc_master;
        end else if (acc_done | timeout_evt) begin
            busy_ff       <= 1'b0;
        end
    end

    timeout_counter #(
        .W       (CW)
    ) u_count (
        .clk     (clk),
        .reset   (reset),
        .start   (acc_start),
        .stop    (acc_done | ~busy_ff),
        .enable  (detect_on),
        .limit   (limit_ff),
        .expired (expired)
    );

    assign timeout_evt = expired & busy_ff & ~acc_start;

    // Owner of the stalled access
    assign is_core       = (cur_master_ff == `MASTER_CORE);
    assign werr_evt      = timeout_evt & cur_write_ff & is_core;
    assign core_read_evt = timeout_evt & ~cur_write_ff & is_core;
    assign pci_evt       = timeout_evt & (cur_master_ff == `MASTER_PCI);
    assign dma_evt       = timeout_evt & (cur_master_ff == `MASTER_DMA);

    ////////////////////////////////////////////////////////////////////////////////
    // Error delivery to the master that stalled

    always @(posedge clk) begin
        if (reset) begin
            err_resp_ff       <= 1'b0;
            core_bus_error_ff <= 1'b0;
            pci_error_ff      <= 1'b0;
            dma_error_ff      <= 1'b0;
        end else begin
            err_resp_ff       <= timeout_evt;
            // Only the owner of the stalled access sees its pulse
            core_bus_error_ff <= core_read_evt;
            pci_error_ff      <= pci_evt;
            dma_error_ff      <= dma_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stalled address capture

    assign addr_ext = {{(64-ADDR_W){1'b0}}, cur_addr_ff};

    always @(posedge clk) begin
        if (reset) begin
            capture_ff <= 64'h0000000000000000;
        end else if (timeout_evt) begin
            capture_ff <= addr_ext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chip setup register

    assign werr_clear = wr_stb & (wr_addr == `OFS_SETUP_LO)
                        & wr_data[`SETUP_WERR_BIT];

    // Set wins over a same-cycle clear
    always @* begin
        nxt_werr_flag = werr_flag_ff;
        if (werr_clear) begin
            nxt_werr_flag = 1'b0;
        end
        if (werr_evt) begin
            nxt_werr_flag = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            enable_ff    <= `SETUP_ENABLE_RST;
            sel_ff       <= `SETUP_SEL_RESET;
            werr_flag_ff <= 1'b0;
        end else begin
            werr_flag_ff <= nxt_werr_flag;
            if (wr_stb && wr_addr == `OFS_SETUP_LO) begin
                enable_ff <= wr_data[`SETUP_ENABLE_BIT];
                sel_ff    <= wr_data[`SETUP_SEL_MSB:`SETUP_SEL_LSB];
            end
        end
    end

    assign setup_lo_word = ({31'h00000000, enable_ff} << `SETUP_ENABLE_BIT)
                           | ({31'h00000000, werr_flag_ff} << `SETUP_WERR_BIT)
                           | ({30'h00000000, sel_ff} << `SETUP_SEL_LSB);

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    assign status_read = rd_stb & (rd_addr == `OFS_INT_STATUS);

    // Read clears; an event in the same cycle survives
    always @* begin
        nxt_status = status_ff;
        if (status_read) begin
            nxt_status = {`INT_WIDTH{1'b0}};
        end
        if (timeout_evt) begin
            nxt_status[`INT_TIMEOUT_BIT] = 1'b1;
        end
        if (werr_evt) begin
            nxt_status[`INT_WERR_BIT] = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            status_ff <= {`INT_WIDTH{1'b0}};
            mask_ff   <= {`INT_WIDTH{1'b0}};
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff    <= |(nxt_status & mask_ff);
            if (wr_stb && wr_addr == `OFS_INT_MASK) begin
                mask_ff <= wr_data[`INT_WIDTH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, sampled in the address phase

    always @* begin
        case (rd_addr)
            `OFS_SETUP_LO: begin
                nxt_hrdata = setup_lo_word;
            end
            `OFS_SETUP_HI: begin
                nxt_hrdata = `WORD_ZERO;
            end
            `OFS_CAPTURE_LO: begin
                nxt_hrdata = capture_ff[`HALF_WIDTH-1:0];
            end
            `OFS_CAPTURE_HI: begin
                nxt_hrdata = capture_ff[63:`HALF_WIDTH];
            end
            `OFS_INT_STATUS: begin
                nxt_hrdata = {{(32-`INT_WIDTH){1'b0}}, status_ff};
            end
            `OFS_INT_MASK: begin
                nxt_hrdata = {{(32-`INT_WIDTH){1'b0}}, mask_ff};
            end
            default: begin
                nxt_hrdata = `WORD_ZERO;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            hrdata_ff <= `WORD_ZERO;
        end else if (rd_stb) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

endmodule

/* rtl/timeout_counter.v */
`timescale 1ns/1ps
`include "timeout_monitor_consts.vh"

module timeout_counter #(
    parameter W = `COUNT_WIDTH
) (
    input  wire         clk,
    input  wire         reset,
    input  wire         start,
    input  wire         stop,
    input  wire         enable,
    input  wire [W-1:0] limit,
    output wire         expired
);

    reg         run_ff;
    reg [W-1:0] cnt_ff;

    assign expired = run_ff & enable & ~stop & (cnt_ff == limit);

    always @(posedge clk) begin
        if (reset) begin
            run_ff <= 1'b0;
            cnt_ff <= {W{1'b0}};
        end else if (start) begin
            run_ff <= enable;
            cnt_ff <= {{(W-1){1'b0}}, 1'b1};
        end else if (stop | expired | ~enable) begin
            run_ff <= 1'b0;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule

/* testbench/bus_far_side.sv */
`timescale 1ns/1ps
module bus_far_side (
    input wire        clk,
    output reg        acc_start,
    output reg [31:0] acc_addr,
    output reg        acc_write,
    output reg [1:0]  acc_master,
    output reg        acc_done,
    input wire        pci_error,
    input wire        dma_error
);
    reg pci_err_ff;
    reg dma_err_ff;
    initial begin
        {acc_start, acc_addr, acc_write, acc_master, acc_done} = 37'h0;
        pci_err_ff = 1'b0;
        dma_err_ff = 1'b0;
    end
    // The PCI and DMA masters each keep their own error bit
    always @(posedge clk) begin
        if (pci_error) pci_err_ff <= 1'b1;
        if (dma_error) dma_err_ff <= 1'b1;
    end
    // Zero wait means the slave never answers
    task access(input [31:0] a, input w, input [1:0] m, input integer wait_n);
        acc_start  <= 1'b1;
        acc_addr   <= a;
        acc_write  <= w;
        acc_master <= m;
        @(posedge clk);
        acc_start <= 1'b0;
        acc_addr  <= ~a;
        acc_write <= ~w;
        if (wait_n > 0) begin
            repeat (wait_n - 1) @(posedge clk);
            acc_done <= 1'b1;
            @(posedge clk);
            acc_done <= 1'b0;
        end
    endtask
endmodule

/* testbench/internal_bus_timeout_monitor_test.sv */
`timescale 1ns/1ps
module internal_bus_timeout_monitor_test;
    reg         clk, reset, hsel, hwrite, debug_reset_n, rd_dp;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg  [31:0] haddr, hwdata, a, a2;
    wire        hreadyout, hresp, acc_start, acc_write, acc_done, err_resp;
    wire        core_bus_error, pci_error, dma_error, irq_source1, irq;
    wire [1:0]  acc_master;
    wire [31:0] hrdata, acc_addr;
    reg  [18:0] e;
    reg  [31:0] rd_q[$];
    reg  [18:0] err_q[$];
    integer     bad_count, check_count, cyc, since, seed, i;
    bus_timeout_monitor bus_timeout_monitor_i (.clk(clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .debug_reset_n(debug_reset_n), .acc_start(acc_start), .acc_addr(acc_addr),
        .acc_write(acc_write), .acc_master(acc_master), .acc_done(acc_done),
        .err_resp(err_resp), .core_bus_error(core_bus_error), .pci_error(pci_error),
        .dma_error(dma_error), .irq_source1(irq_source1), .irq(irq));
    bus_far_side bus_far_side_i (.clk(clk), .acc_start(acc_start), .acc_addr(acc_addr),
        .acc_write(acc_write), .acc_master(acc_master), .acc_done(acc_done),
        .pci_error(pci_error), .dma_error(dma_error));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task wait_cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task bus_cycle(input [31:0] ad, input w, input [31:0] d);
        hsel   <= 1'b1;
        haddr  <= ad;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
    endtask
    task reg_rd(input [31:0] ad, input [31:0] exp);
        rd_q.push_back(exp);
        bus_cycle(ad, 1'b0, 32'h00000000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Result watcher and hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            bad_count = bad_count + 1;
            close_out;
        end
        if (rd_dp && hreadyout) chk("hrdata", rd_q.pop_front(), hrdata);
        rd_dp <= hsel && hreadyout && htrans[1] && !hwrite;
        if (err_resp && err_q.size() == 0) chk("stray err_resp", 0, 1);
        else if (err_resp) begin
            e = err_q.pop_front();
            chk("err cycles", {16'h0000, e[15:0]}, since);
            chk("err route", {29'h0, e[18:16]}, {29'h0, core_bus_error, pci_error, dma_error});
        end
        since = acc_start ? 0 : since + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, rd_dp, debug_reset_n} = 70'h0;
        hsize = 3'h2;
        reset = 1'b1;
        {bad_count, check_count, cyc, since} = 128'h0;
        seed = 32'h595A7410;
        wait_cyc(6);
        reset <= 1'b0;
        @(posedge clk);
        reg_rd(32'h0000E000, 32'h06000000);
        reg_rd(32'h0000E004, 32'h00000000);
        bus_cycle(32'h0000E018, 1'b1, 32'hFFFFFFFF);
        bus_cycle(32'h0000E008, 1'b1, 32'hFFFFFFFF);
        for (i = 0; i < 6; i = i + 1) reg_rd(32'h0000E008 + i * 4, 32'h00000000);
        reg_rd(32'h0000E100, 32'h00000000);
        reg_rd(32'h0000E104, 32'h00000000);
        bus_far_side_i.access($random(seed), 1'b1, 2'h0, 0);
        wait_cyc(4200);
        $display("test reset and disabled done");
        bus_cycle(32'h0000E104, 1'b1, 32'h00000003);
        for (i = 0; i < 4; i = i + 1) begin
            a = $random(seed);
            bus_cycle(32'h0000E000, 1'b1, 32'h00004000 | (i << 25));
            reg_rd(32'h0000E000, 32'h00004000 | (i << 25));
            err_q.push_back({i == 1, i == 2, i == 3, 16'(512 << i)});
            bus_far_side_i.access(a, i % 2 == 0, (i < 2) ? 2'h0 : i - 1, 0);
            wait_cyc((512 << i) + 8);
            chk("write flag", i == 0, irq_source1);
            chk("irq", 1, irq);
            reg_rd(32'h0000E018, a);
            reg_rd(32'h0000E01C, 32'h00000000);
            reg_rd(32'h0000E100, (i == 0) ? 32'h00000003 : 32'h00000001);
            reg_rd(32'h0000E100, 32'h00000000);
            bus_cycle(32'h0000E000, 1'b1, 32'h0000C000 | (i << 25));
            wait_cyc(2);
            chk("flag clear", 0, {irq_source1, irq});
        end
        chk("own error bits", 3, {bus_far_side_i.pci_err_ff, bus_far_side_i.dma_err_ff});
        $display("test select codes done");
        bus_cycle(32'h0000E104, 1'b1, 32'h00000000);
        bus_cycle(32'h0000E000, 1'b1, 32'h00004000);
        bus_far_side_i.access($random(seed), 1'b1, 2'h0, 100);
        wait_cyc(700);
        err_q.push_back({3'h4, 16'h0200});
        bus_far_side_i.access($random(seed), 1'b0, 2'h0, 0);
        wait_cyc(300);
        a2 = $random(seed);
        bus_far_side_i.access(a2, 1'b0, 2'h0, 0);
        wait_cyc(520);
        chk("irq masked", 0, irq);
        reg_rd(32'h0000E018, a2);
        bus_cycle(32'h0000E104, 1'b1, 32'h00000001);
        wait_cyc(2);
        chk("irq unmasked", 1, irq);
        reg_rd(32'h0000E100, 32'h00000001);
        wait_cyc(2);
        chk("irq after read", 0, irq);
        $display("test cancel restart mask done");
        debug_reset_n <= 1'b1;
        wait_cyc(4);
        bus_far_side_i.access($random(seed), 1'b1, 2'h0, 0);
        wait_cyc(600);
        debug_reset_n <= 1'b0;
        wait_cyc(600);
        chk("queues empty", 0, err_q.size() + rd_q.size());
        $display("test debug probe done");
        close_out;
    end
endmodule

/* testbench/timeout_monitor_props.sv */
`timescale 1ns/1ps
module timeout_monitor_props (
    input wire       clk,
    input wire       reset,
    input wire       hsel,
    input wire [1:0] htrans,
    input wire       hwrite,
    input wire       hready,
    input wire       hreadyout,
    input wire       hresp,
    input wire       debug_reset_n,
    input wire       acc_start,
    input wire       acc_write,
    input wire [1:0] acc_master,
    input wire       acc_done,
    input wire       err_resp,
    input wire       core_bus_error,
    input wire       pci_error,
    input wire       dma_error,
    input wire       irq_source1
);
    reg        pend_ff;
    reg [12:0] cnt_ff;
    reg [1:0]  mst_ff;
    reg        wr_ff;
    reg        wph_ff;
    // Track the open access, its age and owner
    always @(posedge clk) begin
        if (reset) begin
            pend_ff <= 1'b0;
            cnt_ff  <= 13'h0000;
            mst_ff  <= 2'h0;
            wr_ff   <= 1'b0;
            wph_ff  <= 1'b0;
        end else begin
            wph_ff <= hsel & hready & htrans[1] & hwrite;
            if (acc_start) begin
                pend_ff <= 1'b1;
                cnt_ff  <= 13'h0000;
                mst_ff  <= acc_master;
                wr_ff   <= acc_write;
            end else begin
                if (acc_done || err_resp) pend_ff <= 1'b0;
                if (cnt_ff != 13'h1FFF) cnt_ff <= cnt_ff + 13'h0001;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_done;
        pend_ff && acc_done && !acc_start;
    endsequence
    sequence s_quiet;
        !acc_start [*2];
    endsequence
    a_err_at_limit: assert property (err_resp |-> pend_ff &&
        (cnt_ff inside {13'h0200, 13'h0400, 13'h0800, 13'h1000})) else $error("err_resp off limit");
    a_err_single: assert property (err_resp |=> !err_resp)
        else $error("err_resp longer than one cycle");
    a_route_master: assert property (err_resp |->
        core_bus_error == (mst_ff == 2'h0 && !wr_ff) && pci_error == (mst_ff == 2'h1)
        && dma_error == (mst_ff == 2'h2)) else $error("error routed to wrong master");
    a_no_stray_pulse: assert property ((core_bus_error || pci_error || dma_error) |-> err_resp)
        else $error("master error without err_resp");
    a_flag_on_write: assert property (err_resp && mst_ff == 2'h0 && wr_ff |-> irq_source1)
        else $error("write flag not set");
    a_flag_only_write: assert property ($rose(irq_source1) |-> err_resp && mst_ff == 2'h0 && wr_ff)
        else $error("write flag set without core write timeout");
    a_flag_sticky: assert property (irq_source1 && !wph_ff |=> irq_source1)
        else $error("write flag dropped");
    a_debug_blocks: assert property (debug_reset_n [*4] |-> !err_resp)
        else $error("timeout with probe attached");
    a_done_cancels: assert property (s_done ##1 s_quiet |-> !err_resp)
        else $error("timeout after response");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("register bus not ready or not okay");
endmodule
bind bus_timeout_monitor timeout_monitor_props timeout_monitor_props_i (.clk(clk), .reset(reset),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .debug_reset_n(debug_reset_n), .acc_start(acc_start), .acc_write(acc_write),
    .acc_master(acc_master), .acc_done(acc_done), .err_resp(err_resp),
    .core_bus_error(core_bus_error), .pci_error(pci_error), .dma_error(dma_error),
    .irq_source1(irq_source1));
